/* File: design/ptr_pkg.sv */
package ptr_pkg;

    // ==========================================================
    // register map
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] DIAG_OFFSET = 8'h00;

    // ==========================================================
    // field layout of the diagnostic access register
    localparam int SEL_LSB    = 0;
    localparam int SEL_W      = 3;
    localparam int CMP_RES_BIT = 3;
    localparam int CMP_SEL_LSB = 4;
    localparam int CMP_SEL_W   = 4;

    // ==========================================================
    // channel encodings of the selector
    typedef enum logic [2:0] {
        CH_RED    = 3'b000,
        CH_GREEN  = 3'b001,
        CH_BLUE   = 3'b010,
        CH_IDENT  = 3'b011,
        CH_ACC_R  = 3'b100,
        CH_ACC_G  = 3'b101,
        CH_ACC_B  = 3'b110,
        CH_ANALOG = 3'b111
    } ptr_chan_e;

    // ==========================================================
    // comparator select codes
    localparam logic [3:0] CMP_NORMAL    = 4'h0;
    localparam logic [3:0] CMP_RED_BLUE  = 4'hA;
    localparam logic [3:0] CMP_RED_REF   = 4'h9;
    localparam logic [3:0] CMP_GREEN_BLU = 4'h6;
    localparam logic [3:0] CMP_GREEN_REF = 4'h5;

    // ==========================================================
    // reset values
    localparam ptr_chan_e  SEL_RST     = CH_RED;
    localparam logic [3:0] CMP_SEL_RST = CMP_NORMAL;
    localparam logic [7:0] ACC_RST     = 8'h00;

    // ==========================================================
    // number of set bits in a colour byte
    function automatic logic [3:0] ptr_popcount(input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, b[i]};
        end
        return n;
    endfunction : ptr_popcount

endpackage : ptr_pkg

/* File: design/ptr_ones_acc.sv */
`timescale 1ns/1ps
`default_nettype none
module ptr_ones_acc
    import ptr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sample_i,
    input  wire logic       clear_i,
    input  wire logic [7:0] byte_i,
    output logic      [7:0] acc_o
);

    typedef struct packed {
        logic [7:0] acc;
    } ptr_acc_s;

    ptr_acc_s st_reg;
    ptr_acc_s st_next;

    // ==========================================================
    // temporary accumulator
    // clear wins over a sample: the frame boundary closes the sum
    always_comb begin
        st_next = st_reg;
        if (clear_i) begin
            st_next.acc = ACC_RST;
        end else if (sample_i) begin
            // wraps past 255, no saturation
            st_next.acc = st_reg.acc + {4'h0, ptr_popcount(byte_i)};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.acc <= ACC_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign acc_o = st_reg.acc;

    // ==========================================================
    // checks
    a_acc_sum_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_i && !clear_i |=>
        acc_o == 8'($past(acc_o) + {4'h0, ptr_popcount($past(byte_i))}))
        else $error("accumulator sum wrong");

    a_acc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clear_i |=> acc_o == 8'h00)
        else $error("accumulator not cleared");

endmodule : ptr_ones_acc
`default_nettype wire

/* File: design/ptr_test_reg.sv */
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ptr_test_reg
    import ptr_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              pixel_en_i,
    input  wire logic              clk_src_change_i,
    input  wire logic [7:0]        red_i,
    input  wire logic [7:0]        green_i,
    input  wire logic [7:0]        blue_i,
    input  wire logic              vsync_n_i,
    input  wire logic              blank_n_i,
    input  wire logic              cmp_result_i,
    output logic      [3:0]        cmp_select_o,
    output logic      [2:0]        channel_o
);

    // ==========================================================
    // state of the block
    typedef struct packed {
        ptr_chan_e       sel;
        logic [3:0]      cmp_sel;
        logic            cmp_res;
        logic [2:0][7:0] res;
        logic            vsync_q;
        logic            blank_q;
        logic            blank_q2;
        logic            phase;
        logic            ack;
        logic [7:0]      dat;
    } ptr_state_s;

    ptr_state_s st_reg;
    ptr_state_s st_next;

    // ==========================================================
    // bus decode
    logic       req_w;
    logic       hit_w;
    logic       wr_take_w;
    logic       rd_take_w;

    // a request is taken once; the ack cycle itself is not a new one
    assign req_w     = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign hit_w     = (wb_adr_i[ADDR_W-1:2] == DIAG_OFFSET[ADDR_W-1:2]);
    assign wr_take_w = req_w & hit_w & wb_we_i & wb_sel_i[0];
    assign rd_take_w = req_w & hit_w & ~wb_we_i;

    // ==========================================================
    // video side events
    logic       frame_fall_w;
    logic       blank_fall_w;
    logic       acc_mode_w;
    logic       sample_w;
    logic [7:0] acc_byte_w;
    logic [7:0] acc_w;

    // only the frame sync pin counts; composite sync never reaches here
    assign frame_fall_w = st_reg.vsync_q & ~vsync_n_i;

    // internal strobe is blanking delayed by one cycle
    assign blank_fall_w = st_reg.blank_q2 & ~st_reg.blank_q;

    assign acc_mode_w = st_reg.sel[2] & (st_reg.sel != CH_ANALOG);

    // phase gates every second pixel enable
    assign sample_w = pixel_en_i & st_reg.phase & acc_mode_w;

    // colour byte follows the selector, which holds all frame unless a host write loads it
    always_comb begin
        case (st_reg.sel)
            CH_ACC_R: acc_byte_w = red_i;
            CH_ACC_G: acc_byte_w = green_i;
            CH_ACC_B: acc_byte_w = blue_i;
            default:  acc_byte_w = 8'h00;
        endcase
    end

    // ==========================================================
    // ones accumulation engine
    ptr_ones_acc u_acc (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (sample_w),
        .clear_i  (frame_fall_w),
        .byte_i   (acc_byte_w),
        .acc_o    (acc_w)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic [7:0] rd_data;
        rd_data = 8'h00;
        st_next = st_reg;
        st_next.ack      = 1'b0;
        st_next.vsync_q  = vsync_n_i;
        st_next.blank_q  = blank_n_i;
        st_next.blank_q2 = st_reg.blank_q;

        // phase restarts only on a clock source change, never at a frame boundary
        if (clk_src_change_i) begin
            st_next.phase = 1'b0;
        end else if (pixel_en_i) begin
            st_next.phase = ~st_reg.phase;
        end

        // frame end: store sum of this colour, move to next colour
        if (frame_fall_w) begin
            case (st_reg.sel)
                CH_ACC_R: begin
                    st_next.res[0] = acc_w;
                    st_next.sel    = CH_ACC_G;
                end
                CH_ACC_G: begin
                    st_next.res[1] = acc_w;
                    st_next.sel    = CH_ACC_B;
                end
                CH_ACC_B: begin
                    st_next.res[2] = acc_w;
                    st_next.sel    = CH_ACC_R;
                end
                default: begin
                end
            endcase
        end

        // comparator outcome strobed at end of active video
        if (blank_fall_w) begin
            st_next.cmp_res = cmp_result_i;
        end

        // read data of the channel in the selector
        case (st_reg.sel)
            CH_RED:    rd_data = red_i;
            CH_GREEN:  rd_data = green_i;
            CH_BLUE:   rd_data = blue_i;
            CH_IDENT:  rd_data = ID_CODE;
            CH_ACC_R:  rd_data = st_reg.res[0];
            CH_ACC_G:  rd_data = st_reg.res[1];
            CH_ACC_B:  rd_data = st_reg.res[2];
            CH_ANALOG: rd_data = {st_reg.cmp_sel, st_reg.cmp_res, 3'b111};
            default:   rd_data = 8'h00;
        endcase

        // bus access: one-cycle answer, unmapped reads give zero
        if (req_w) begin
            st_next.ack = 1'b1;
            st_next.dat = 8'h00;
        end

        if (wr_take_w) begin
            // a host write overrides the frame advance
            st_next.sel     = ptr_chan_e'(wb_dat_i[SEL_LSB +: SEL_W]);
            // result bit is not writable
            st_next.cmp_sel = wb_dat_i[CMP_SEL_LSB +: CMP_SEL_W];
        end else if (rd_take_w) begin
            st_next.dat = rd_data;
            // ident and colours step on; sums and analog stay put
            case (st_reg.sel)
                CH_RED:   st_next.sel = CH_GREEN;
                CH_GREEN: st_next.sel = CH_BLUE;
                CH_BLUE:  st_next.sel = CH_RED;
                CH_IDENT: st_next.sel = CH_RED;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.sel      <= SEL_RST;
            st_reg.cmp_sel  <= CMP_SEL_RST;
            st_reg.cmp_res  <= 1'b0;
            st_reg.res      <= '0;
            st_reg.vsync_q  <= 1'b1;
            st_reg.blank_q  <= 1'b1;
            st_reg.blank_q2 <= 1'b1;
            st_reg.phase    <= 1'b0;
            st_reg.ack      <= 1'b0;
            st_reg.dat      <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs, all from flops
    assign wb_dat_o     = {24'h000000, st_reg.dat};
    assign wb_ack_o     = st_reg.ack;
    // select code goes straight to the comparator mux
    assign cmp_select_o = st_reg.cmp_sel;
    assign channel_o    = st_reg.sel;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_read_ident;
        rd_take_w && st_reg.sel == CH_IDENT;
    endsequence

    sequence s_ident_out;
        wb_ack_o && wb_dat_o[7:0] == ID_CODE && channel_o == CH_RED;
    endsequence

    a_write_loads_sel: assert property (
        wr_take_w |=> channel_o == $past(wb_dat_i[2:0]))
        else $error("selector not loaded by write");

    a_read_ident_code: assert property (
        s_read_ident |=> s_ident_out)
        else $error("ident read wrong");

    a_read_colour_byte: assert property (
        rd_take_w && st_reg.sel == CH_GREEN |=>
        wb_dat_o[7:0] == $past(green_i) && channel_o == CH_BLUE)
        else $error("green read wrong");

    a_colour_wrap_red: assert property (
        rd_take_w && st_reg.sel == CH_BLUE |=> channel_o == CH_RED)
        else $error("blue did not wrap to red");

    a_ident_no_return: assert property (
        st_reg.sel != CH_IDENT && !wr_take_w |=> channel_o != CH_IDENT)
        else $error("selector returned to ident");

    a_acc_store_clear: assert property (
        frame_fall_w && st_reg.sel == CH_ACC_G |=>
        st_reg.res[1] == $past(acc_w) && acc_w == 8'h00)
        else $error("green sum not stored");

    a_acc_advance_wrap: assert property (
        frame_fall_w && st_reg.sel == CH_ACC_B && !wr_take_w |=>
        channel_o == CH_ACC_R)
        else $error("blue sum did not advance to red");

    a_acc_colour_hold: assert property (
        acc_mode_w && !frame_fall_w && !wr_take_w |=> $stable(channel_o))
        else $error("summed colour changed mid frame");

    a_half_rate_sample: assert property (
        sample_w |=> !sample_w)
        else $error("two samples back to back");

    a_phase_hold: assert property (
        !pixel_en_i && !clk_src_change_i |=> $stable(st_reg.phase))
        else $error("sample phase drifted");

    a_cmp_latch: assert property (
        $past(blank_n_i, 2) && !$past(blank_n_i) |->
        ##1 st_reg.cmp_res == $past(cmp_result_i))
        else $error("comparator result not latched");

    a_analog_read: assert property (
        rd_take_w && st_reg.sel == CH_ANALOG |=>
        wb_dat_o[7:0] == {$past(st_reg.cmp_sel), $past(st_reg.cmp_res), 3'b111}
        && channel_o == CH_ANALOG)
        else $error("analog read wrong");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // ==========================================================
    // bus answer and channel step checks
    a_ack_after_req: assert property (
        req_w |=> wb_ack_o)
        else $error("request not answered next cycle");

    // an unmapped place still answers so the host never hangs
    a_unmapped_read_zero: assert property (
        req_w && !hit_w |=> wb_dat_o == 32'h00000000)
        else $error("unmapped access gave data");

    // colour reads see the live byte, then step on
    a_red_step_green: assert property (
        rd_take_w && st_reg.sel == CH_RED |=>
        wb_dat_o[7:0] == $past(red_i) && channel_o == CH_GREEN)
        else $error("red read wrong");

    a_blue_read_byte: assert property (
        rd_take_w && st_reg.sel == CH_BLUE |=> wb_dat_o[7:0] == $past(blue_i))
        else $error("blue read wrong");

    a_sum_read_red: assert property (
        rd_take_w && st_reg.sel == CH_ACC_R |=> wb_dat_o[7:0] == $past(st_reg.res[0]))
        else $error("red sum read wrong");

    // each frame end moves the summed colour on
    a_acc_advance_red: assert property (
        frame_fall_w && st_reg.sel == CH_ACC_R && !wr_take_w |=> channel_o == CH_ACC_G)
        else $error("red sum did not advance to green");

    // a strobe in the write cycle may still move the result bit
    a_result_read_only: assert property (
        wr_take_w && !blank_fall_w |=>
        st_reg.cmp_res == $past(st_reg.cmp_res) && cmp_select_o == $past(wb_dat_i[7:4]))
        else $error("write reached result bit");

endmodule : ptr_test_reg
`default_nettype wire

/* File: tb/ptr_video_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// video side: random pixels, 32-clock lines, frame sync at frame end
module ptr_video_src #(
    parameter int FRAME = 512
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       hold_i,
    output logic            pixel_en_o,
    output logic      [7:0] red_o,
    output logic      [7:0] green_o,
    output logic      [7:0] blue_o,
    output logic            vsync_n_o,
    output logic            blank_n_o,
    output logic            cmp_result_o
);
    integer      seed = 32'h96e50052;
    int          cnt  = 0;
    logic [31:0] r;
    initial {pixel_en_o, red_o, green_o, blue_o, vsync_n_o, blank_n_o, cmp_result_o} = 28'h0000006;
    // bytes move only with a pixel, never while the host holds them
    always @(posedge clk_i) begin
        r = $random(seed);
        cnt        <= rst_i ? 0 : (cnt + 1) % FRAME;
        pixel_en_o <= r[31] && !rst_i;
        if (!hold_i && r[31]) begin
            {red_o, green_o, blue_o} <= r[23:0];
        end
        vsync_n_o <= cnt < FRAME - 6;
        blank_n_o <= cnt % 32 < 24;
        // comparator input moves at line start, well clear of the strobe
        if (cnt % 32 == 0) begin
            cmp_result_o <= r[30];
        end
    end
endmodule : ptr_video_src
`default_nettype wire

/* File: tb/test_palette_test_register.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench: bus driver, cycle model, comparisons
module test_palette_test_register;
    import ptr_pkg::*;
    localparam int         FRAME = 512;
    localparam logic [7:0] TB_ID = 8'h3C; // arbitrary identification value
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, hold = 1'b0, src_chg = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r, m_dat, r;
    logic        ack, pix_en, vsync_n, blank_n, cmp;
    logic [7:0]  red, green, blue, m_acc;
    logic [7:0]  m_res [3];
    logic [3:0]  cs_o, m_cs;
    logic [3:0]  codes [5] = '{CMP_NORMAL, CMP_RED_BLUE, CMP_RED_REF, CMP_GREEN_BLU, CMP_GREEN_REF};
    logic [2:0]  ch_o, m_sel, nsel;
    logic        m_cres, m_ph, m_ack, v_prev, bl1, bl2, take, hit;
    integer      seed = 32'h96e50052;
    int          bad_count = 0;
    int          compares = 0;

    ptr_video_src #(.FRAME(FRAME)) vsrc (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold),
        .pixel_en_o(pix_en), .red_o(red), .green_o(green), .blue_o(blue),
        .vsync_n_o(vsync_n), .blank_n_o(blank_n), .cmp_result_o(cmp));
    ptr_test_reg #(.ID_CODE(TB_ID)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .pixel_en_i(pix_en), .clk_src_change_i(src_chg), .red_i(red), .green_i(green),
        .blue_i(blue), .vsync_n_i(vsync_n), .blank_n_i(blank_n), .cmp_result_i(cmp),
        .cmp_select_o(cs_o), .channel_o(ch_o));

    initial forever #5 clk_i = ~clk_i;

    // ==========================================
    // cycle model: reads see old register values, then state moves on
    always @(posedge clk_i) begin
        take  = cyc && stb && !m_ack;
        hit   = take && adr[7:2] == 6'h00;
        nsel  = m_sel;
        m_dat = 32'h0;
        if (rst_i) begin
            {m_sel, m_cs, m_acc, m_cres, m_ph, m_ack} = '0;
            m_res = '{8'h00, 8'h00, 8'h00};
            {v_prev, bl1, bl2} = 3'b111;
        end else begin
            if (hit && !we) begin
                case (m_sel)
                    3'd0: m_dat = {24'h0, red};
                    3'd1: m_dat = {24'h0, green};
                    3'd2: m_dat = {24'h0, blue};
                    3'd3: m_dat = {24'h0, TB_ID};
                    3'd7: m_dat = {24'h0, m_cs, m_cres, 3'b111};
                    default: m_dat = {24'h0, m_res[m_sel - 3'd4]};
                endcase
                if (m_sel < 3'd4) nsel = (m_sel >= 3'd2) ? 3'd0 : m_sel + 3'd1;
            end
            if (v_prev && !vsync_n) begin
                if (m_sel >= 3'd4 && m_sel <= 3'd6) begin
                    m_res[m_sel - 3'd4] = m_acc;
                    nsel = (m_sel == 3'd6) ? 3'd4 : m_sel + 3'd1;
                end
                m_acc = 8'h00;
            end else if (pix_en && m_ph && m_sel >= 3'd4 && m_sel <= 3'd6) begin
                // wraps by width, never saturates
                m_acc = m_acc + 8'($countones(m_sel == 3'd4 ? red : m_sel == 3'd5 ? green : blue));
            end
            m_ph = src_chg ? 1'b0 : m_ph ^ pix_en;
            if (bl2 && !bl1) m_cres = cmp;
            {bl2, bl1, v_prev} = {bl1, blank_n, vsync_n};
            if (hit && we && sel[0]) begin
                nsel = dat_w[2:0];
                m_cs = dat_w[7:4];
            end
            m_sel = nsel;
            m_ack = take;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // selector and select bits are register state, kept apart from bus answers
    task automatic chk_state(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_state

    // outputs are settled by the falling edge
    always @(negedge clk_i) begin
        if (!rst_i) begin
            chk({31'h0, ack}, {31'h0, m_ack});
            if (m_ack) chk(dat_r, m_dat);
            chk_state({29'h0, ch_o}, {29'h0, m_sel});
            chk_state({28'h0, cs_o}, {28'h0, m_cs});
        end
    end

    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    // classic single cycle; only the watchdog ends a wait with no ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        dat_w <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    initial begin
        #(20000 * 10);
        bad_count++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // let the pixel bytes roll a few cycles, then freeze them for colour reads
        repeat (8) @(posedge clk_i);
        hold <= 1'b1;
        // every selector code, two reads each, pixels held steady
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, 8'h00, 4'h1, 32'(c));
            repeat (2) wb(1'b0, 8'h00, 4'h1, 32'h0);
        end
        wb(1'b1, 8'h00, 4'h1, 32'h3);
        repeat (6) wb(1'b0, 8'h00, 4'h1, 32'h0);
        // unmapped place and a write without the low byte lane
        wb(1'b1, 8'h04, 4'h1, 32'h6);
        wb(1'b0, 8'h08, 4'h1, 32'h0);
        wb(1'b1, 8'h00, 4'hE, 32'h2);
        // screen sums over several frames, phase restarted midway
        hold <= 1'b0;
        wb(1'b1, 8'h00, 4'h1, 32'h4);
        for (int i = 0; i < 9; i++) begin
            repeat (FRAME / 2) @(posedge clk_i);
            if (i == 4) src_chg <= 1'b1;
            wb(1'b0, 8'h00, 4'h1, 32'h0);
            src_chg <= 1'b0;
        end
        // analog test; a one written to the result bit must not stick
        hold <= 1'b1;
        foreach (codes[k]) begin
            wb(1'b1, 8'h00, 4'h1, {24'h0, codes[k], 4'hF});
            repeat (70) @(posedge clk_i);
            wb(1'b0, 8'h00, 4'h1, 32'h0);
        end
        // random traffic; select bits stay zero outside the analog code
        repeat (40) begin
            r = $random(seed);
            wb(r[8], (r[10:9] == 2'b11) ? 8'h04 : 8'h00, {3'h0, r[11] | r[12]},
               {24'h0, (r[2:0] == 3'd7) ? r[7:4] : 4'h0, r[3], r[2:0]});
        end
        results();
    end
endmodule : test_palette_test_register
`default_nettype wire
